/* File: hdl/bit_codec_defs.vh */
// Constants shared by the contactless bit codec
`ifndef BIT_CODEC_DEFS_VH
`define BIT_CODEC_DEFS_VH
// Carrier periods per bit at each rate
`define VT_BIT_CARRIERS    10'h200
`define P106_BIT_CARRIERS  10'h080
`define P212_BIT_CARRIERS  10'h040
`define P424_BIT_CARRIERS  10'h020
// Link clock ticks per pause (one pause lasts a slot of 128 ticks / 4)
`define VT_PAUSE_CARRIERS  10'h020
// Modes
`define MODE_VT            3'h0
`define MODE_ACT_INIT      3'h1
`define MODE_ACT_TGT       3'h2
`define MODE_PAS_INIT      3'h3
`define MODE_PAS_TGT       3'h4
// Speeds
`define SPD_106            2'h0
`define SPD_212            2'h1
`define SPD_424            2'h2
// Anti-collision slot count
`define INV_SLOTS          5'h10
`define INV_SLOT_LAST      5'h0f
`define INV_SLOT_BITS      10'h020
`endif

/* File: hdl/codec_fifo.v */
// Data FIFO with valid and ready on both sides
`timescale 1ns/10ps
module codec_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_n_i,
  // Fill side
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  // Drain side
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg             full_n_reg;
  wire            push;
  wire            pop;

  assign in_ready_o  = full_n_reg;
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      full_n_reg <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg  <= count_reg + 1'b1;
        full_n_reg <= (count_reg != DEPTH[AW:0] - 1'b1);
      end else if (pop && !push) begin
        count_reg  <= count_reg - 1'b1;
        full_n_reg <= 1'b1;
      end
    end
  end
endmodule

/* File: hdl/contactless_bit_codec.v */
// Bit coder, decoder and role control of the contactless controller
`timescale 1ns/10ps
`include "bit_codec_defs.vh"
module contactless_bit_codec #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  // Clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_n_i,
  // Carrier clock from the analog front end
  input  wire       carrier_clk_i,
  // Role selection
  input  wire [2:0] mode_i,
  input  wire [1:0] speed_i,
  input  wire       inventory_i,
  // Transmit byte stream
  input  wire [7:0] tx_data_i,
  input  wire       tx_valid_i,
  output wire       tx_ready_o,
  input  wire       tx_last_i,
  // Receive side
  input  wire       rx_mod_i,
  output reg  [7:0] rx_data_o,
  output reg        rx_valid_o,
  output reg  [4:0] inv_slot_o,
  output reg        inv_done_o,
  // Field control
  output reg        field_on_o,
  output reg        pause_o,
  output reg        load_mod_o,
  output reg        busy_o
);
  //////////////////////////////////////////////////////////////////////////
  // Carrier edge detection
  reg  [2:0] clk_sync_reg;
  wire       carrier_tick;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_sync_reg <= 3'h0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], carrier_clk_i};
    end
  end
  assign carrier_tick = clk_sync_reg[1] && !clk_sync_reg[2];

  reg  [2:0] rx_sync_reg;
  reg        rx_lvl_reg;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sync_reg <= 3'h0;
      rx_lvl_reg  <= 1'b0;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_mod_i};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_lvl_reg <= rx_sync_reg[2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bit length per mode
  function [9:0] bit_len;
    input [2:0] m;
    input [1:0] s;
    begin
      if (m == `MODE_VT) begin
        bit_len = `VT_BIT_CARRIERS;
      end else begin
        case (s)
          `SPD_212: bit_len = `P212_BIT_CARRIERS;
          `SPD_424: bit_len = `P424_BIT_CARRIERS;
          default:  bit_len = `P106_BIT_CARRIERS;
        endcase
      end
    end
  endfunction

  function is_init;
    input [2:0] m;
    begin
      is_init = (m == `MODE_ACT_INIT) || (m == `MODE_PAS_INIT) ||
                (m == `MODE_VT);
    end
  endfunction

  wire [9:0] blen;
  wire [9:0] half_len;
  assign blen     = bit_len(mode_i, speed_i);
  assign half_len = {1'b0, blen[9:1]};

  //////////////////////////////////////////////////////////////////////////
  // Transmit FIFO
  wire [8:0] fifo_out;
  wire       fifo_valid;
  reg        fifo_pop_reg;
  codec_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   ({tx_last_i, tx_data_i}),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop_reg)
  );

  //////////////////////////////////////////////////////////////////////////
  // Sequencer
  localparam ST_IDLE = 4'b0001;
  localparam ST_TX   = 4'b0010;
  localparam ST_RX   = 4'b0100;
  localparam ST_INV  = 4'b1000;

  reg [3:0] state_reg;
  reg [9:0] tick_reg;
  reg [2:0] bit_idx_reg;
  reg [7:0] sh_reg;
  reg       last_reg;
  reg       prev_bit_reg;
  reg       half1_reg;
  reg       rx_first_reg;
  reg [9:0] rx_cnt_reg;
  reg [2:0] rx_bits_reg;
  reg [9:0] rx_idle_reg;
  reg       inv_run_reg;
  reg       frame_open_reg;

  // Pulse position slot: pair of bits picks slot 0..3 of four per bit pair
  wire [1:0] ppm_slot;
  wire [9:0] slot_pos;
  assign ppm_slot = {sh_reg[bit_idx_reg + 3'h1], sh_reg[bit_idx_reg]};
  assign slot_pos = {ppm_slot, 1'b0, 7'h00} + {3'h0, ppm_slot, 5'h00};

  // Next coded level: high means pause or modulation active
  reg        cur_bit;
  reg        tx_mod;
  always @* begin
    cur_bit = sh_reg[bit_idx_reg];
    tx_mod  = 1'b0;
    if (mode_i == `MODE_VT) begin
      // Two bits span two bit times; pause in chosen quarter
      tx_mod = (tick_reg >= slot_pos) &&
               (tick_reg < slot_pos + `VT_PAUSE_CARRIERS);
    end else if (speed_i == `SPD_106 && mode_i == `MODE_ACT_INIT) begin
      // Modified Miller: short pause mid bit for one, start for zero after 0
      tx_mod = cur_bit ? (tick_reg >= half_len &&
                          tick_reg < half_len + 10'h020) :
               (!prev_bit_reg && tick_reg < 10'h020);
    end else if (speed_i == `SPD_106 && mode_i == `MODE_ACT_TGT) begin
      // Miller: transition mid bit for one, at edge between zeros
      tx_mod = cur_bit ? (tick_reg >= half_len) :
               (!prev_bit_reg);
    end else begin
      tx_mod = cur_bit ? (tick_reg < half_len) :
               (tick_reg >= half_len);
    end
  end

  wire [9:0] step_len;
  assign step_len = (mode_i == `MODE_VT) ? {blen[8:0], 1'b0} : blen;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= ST_IDLE;
      tick_reg     <= 10'h000;
      bit_idx_reg  <= 3'h0;
      sh_reg       <= 8'h00;
      last_reg     <= 1'b0;
      prev_bit_reg <= 1'b0;
      fifo_pop_reg <= 1'b0;
      field_on_o   <= 1'b0;
      pause_o      <= 1'b0;
      load_mod_o   <= 1'b0;
      busy_o       <= 1'b0;
      inv_slot_o   <= 5'h00;
      inv_done_o   <= 1'b0;
      inv_run_reg  <= 1'b0;
      frame_open_reg <= 1'b0;
    end else begin
      fifo_pop_reg <= 1'b0;
      inv_done_o   <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          pause_o    <= 1'b0;
          load_mod_o <= 1'b0;
          busy_o     <= 1'b0;
          // Initiators hold the field; targets keep theirs off
          field_on_o <= is_init(mode_i);
          if (fifo_valid && !fifo_pop_reg &&
              (is_init(mode_i) || rx_valid_o || inv_run_reg ||
               frame_open_reg)) begin
            // Targets speak only after a command, then finish the frame
            frame_open_reg <= !fifo_out[8];
            sh_reg       <= fifo_out[7:0];
            last_reg     <= fifo_out[8];
            fifo_pop_reg <= 1'b1;
            bit_idx_reg  <= 3'h0;
            tick_reg     <= 10'h000;
            busy_o       <= 1'b1;
            state_reg    <= ST_TX;
          end else if (inventory_i && mode_i == `MODE_VT) begin
            inv_slot_o  <= 5'h00;
            inv_run_reg <= 1'b1;
            tick_reg    <= 10'h000;
            busy_o      <= 1'b1;
            state_reg   <= ST_INV;
          end
        end
        ST_TX: begin
          if (mode_i == `MODE_PAS_TGT) begin
            field_on_o <= 1'b0;
            load_mod_o <= tx_mod;
          end else if (mode_i == `MODE_ACT_TGT ||
                       mode_i == `MODE_ACT_INIT) begin
            field_on_o <= 1'b1;
            pause_o    <= tx_mod;
          end else begin
            field_on_o <= 1'b1;
            pause_o    <= tx_mod;
          end
          if (carrier_tick) begin
            if (tick_reg == step_len - 10'h001) begin
              tick_reg     <= 10'h000;
              prev_bit_reg <= sh_reg[bit_idx_reg];
              bit_idx_reg  <= bit_idx_reg +
                              ((mode_i == `MODE_VT) ? 3'h2 : 3'h1);
              if (bit_idx_reg >= ((mode_i == `MODE_VT) ? 3'h6 : 3'h7)) begin
                if (last_reg) begin
                  pause_o    <= 1'b0;
                  load_mod_o <= 1'b0;
                  // Active peers drop the carrier to let the other answer
                  if (mode_i == `MODE_ACT_INIT ||
                      mode_i == `MODE_ACT_TGT) begin
                    field_on_o <= 1'b0;
                  end
                  state_reg <= inv_run_reg ? ST_INV : ST_RX;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end
            end else begin
              tick_reg <= tick_reg + 10'h001;
            end
          end
        end
        ST_RX: begin
          if (rx_idle_reg == step_len) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_INV: begin
          // Each slot: wait a fixed window then step to next
          field_on_o <= 1'b1;
          if (carrier_tick) begin
            if (tick_reg == `INV_SLOT_BITS - 10'h001) begin
              tick_reg <= 10'h000;
              if (inv_slot_o == `INV_SLOT_LAST) begin
                inv_run_reg <= 1'b0;
                inv_done_o  <= 1'b1;
                state_reg   <= ST_IDLE;
              end else begin
                inv_slot_o <= inv_slot_o + 5'h01;
              end
            end else begin
              tick_reg <= tick_reg + 10'h001;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver: Manchester level sampled once per bit, near the end of its first half
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_cnt_reg   <= 10'h000;
      rx_bits_reg  <= 3'h0;
      rx_data_o    <= 8'h00;
      rx_valid_o   <= 1'b0;
      half1_reg    <= 1'b0;
      rx_first_reg <= 1'b0;
      rx_idle_reg  <= 10'h000;
    end else begin
      if (state_reg == ST_TX) begin
        rx_valid_o <= 1'b0;
      end
      if (state_reg != ST_RX && state_reg != ST_INV &&
          (state_reg != ST_IDLE || is_init(mode_i))) begin
        rx_cnt_reg   <= 10'h000;
        rx_bits_reg  <= 3'h0;
        rx_first_reg <= 1'b0;
        rx_idle_reg  <= 10'h000;
      end else if (carrier_tick) begin
        if (!rx_first_reg) begin
          if (rx_lvl_reg) begin
            rx_first_reg <= 1'b1;
            rx_cnt_reg   <= 10'h001;
            rx_idle_reg  <= 10'h000;
          end else if (rx_idle_reg != step_len) begin
            rx_idle_reg <= rx_idle_reg + 10'h001;
          end
        end else if (rx_cnt_reg == half_len - 10'h001) begin
          half1_reg  <= rx_lvl_reg;
          rx_cnt_reg <= rx_cnt_reg + 10'h001;
        end else if (rx_cnt_reg == blen - 10'h001) begin
          // One full bit period per symbol; first half high is a one
          rx_cnt_reg  <= 10'h000;
          rx_data_o   <= {half1_reg, rx_data_o[7:1]};
          rx_bits_reg <= rx_bits_reg + 3'h1;
          rx_valid_o  <= (rx_bits_reg == 3'h7);
          rx_first_reg <= (rx_bits_reg != 3'h7);
        end else begin
          rx_cnt_reg <= rx_cnt_reg + 10'h001;
        end
      end
    end
  end
endmodule

/* File: verif/contactless_bit_codec_asserts.sv */
// Port assertions for the contactless bit codec
`timescale 1ns/10ps
`include "bit_codec_defs.vh"
module codec_port_checker (
  // Clock, reset and role
  input wire       sys_clk_i,
  input wire       rst_n_i,
  input wire [2:0] mode_i,
  // Observed outputs
  input wire [7:0] rx_data_o,
  input wire       rx_valid_o,
  input wire [4:0] inv_slot_o,
  input wire       inv_done_o,
  input wire       field_on_o,
  input wire       pause_o,
  input wire       load_mod_o,
  input wire       busy_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_PAS_TGT_DARK: assert property (
    (mode_i == `MODE_PAS_TGT)[*3] |-> !field_on_o)
    else $error("field on as passive target");
  AST_PAS_INIT_LIT: assert property (
    (mode_i == `MODE_PAS_INIT)[*3] |-> field_on_o)
    else $error("no field as passive initiator");
  AST_ACT_TGT_QUIET: assert property (
    (mode_i == `MODE_ACT_TGT && !busy_o)[*3] |-> !field_on_o)
    else $error("idle active target drives field");
  AST_LOAD_ROLE: assert property (
    (mode_i != `MODE_PAS_TGT)[*3] |-> !load_mod_o)
    else $error("load modulation outside passive target");
  AST_INV_PULSE: assert property (
    inv_done_o |=> !inv_done_o)
    else $error("inventory done longer than a cycle");
  AST_INV_RANGE: assert property (
    inv_slot_o <= `INV_SLOT_LAST)
    else $error("inventory slot out of range");
  AST_PAUSE_MIN: assert property (
    $rose(pause_o) && mode_i == `MODE_VT |=> pause_o[*8])
    else $error("tag pause too short");
  AST_RX_HOLD: assert property (
    rx_valid_o && $past(rx_valid_o) |-> $stable(rx_data_o))
    else $error("received byte changed while valid");
endmodule
////////////////////////////////////////////////////////////////////////
bind contactless_bit_codec codec_port_checker u_codec_port_checker (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .mode_i(mode_i),
  .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
  .inv_slot_o(inv_slot_o), .inv_done_o(inv_done_o),
  .field_on_o(field_on_o), .pause_o(pause_o),
  .load_mod_o(load_mod_o), .busy_o(busy_o)
);

/* File: verif/peer_tag_model.sv */
// Far side model: answers one byte as Manchester load modulation
`timescale 1ns/10ps
module peer_tag_model (
  // Link clock and request
  input  wire       carrier_clk_i,
  input  wire       send_i,
  input  wire [7:0] byte_i,
  input  wire [9:0] half_i,
  input  wire [9:0] wait_i,
  // Modulation seen by the codec
  output reg        mod_o
);
  integer b;
  initial begin
    mod_o = 1'b0;
    forever begin
      @(posedge send_i);
      // Answer after a fixed wait of wait_i carrier clocks from the request
      repeat (wait_i) @(posedge carrier_clk_i);
      for (b = 0; b < 8; b = b + 1) begin
        mod_o = byte_i[b];
        repeat (half_i) @(posedge carrier_clk_i);
        mod_o = ~byte_i[b];
        repeat (half_i) @(posedge carrier_clk_i);
      end
      mod_o = 1'b0;
    end
  end
endmodule

/* File: verif/test_contactless_bit_codec.sv */
// Self-checking bench for the contactless bit codec
`timescale 1ns/10ps
`include "bit_codec_defs.vh"
module test_contactless_bit_codec;
  localparam time TICK = 125;
  reg        sys_clk_i, rst_n_i, carrier_clk_i, inventory_i;
  reg  [2:0] mode_i;
  reg  [1:0] speed_i;
  reg  [7:0] tx_data_i, pbyte;
  reg        tx_valid_i, tx_last_i, send;
  reg  [9:0] pwait;
  reg [31:0] rnd;
  wire [7:0] rx_data_o;
  wire [4:0] inv_slot_o;
  wire       tx_ready_o, rx_mod_i, rx_valid_o, inv_done_o;
  wire       field_on_o, pause_o, load_mod_o, busy_o;
  wire [7:0] ev = {~field_on_o, tx_ready_o, ~pause_o, pause_o,
                   inv_done_o, rx_valid_o, load_mod_o, busy_o};
  integer    fail_count, num_checks, seed, i;
  time       t0;
  contactless_bit_codec u_contactless_bit_codec (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .carrier_clk_i(carrier_clk_i), .mode_i(mode_i), .speed_i(speed_i),
    .inventory_i(inventory_i), .tx_data_i(tx_data_i),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .tx_last_i(tx_last_i), .rx_mod_i(rx_mod_i), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .inv_slot_o(inv_slot_o),
    .inv_done_o(inv_done_o), .field_on_o(field_on_o),
    .pause_o(pause_o), .load_mod_o(load_mod_o), .busy_o(busy_o));
  peer_tag_model u_peer_tag_model (
    .carrier_clk_i(carrier_clk_i), .send_i(send), .byte_i(pbyte),
    .half_i(10'h010), .wait_i(pwait), .mod_o(rx_mod_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    carrier_clk_i = 1'b0;
    #37.3;
    forever #62.5 carrier_clk_i = ~carrier_clk_i;
  end
  initial begin
    #450_000;
    fail_count = fail_count + 1;
    finish_test;
  end
  task check(input string what, input [7:0] exp, input [7:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  function [7:0] near(input time got, input time want, input time tol);
    near = (got + tol >= want && got <= want + tol) ? 8'h01 : 8'h00;
  endfunction
  task span(input string what, input time want, input time tol);
    check(what, 8'h01, near($time - t0, want, tol));
  endtask
  task wait_ev(input integer sel, input integer lim);
    integer k;
    begin
      k = 0;
      @(negedge sys_clk_i);
      while (ev[sel] !== 1'b1 && k < lim) begin
        @(negedge sys_clk_i);
        k = k + 1;
      end
      check("event wait", 8'h01, {7'h00, k < lim});
    end
  endtask
  task push(input [7:0] d, input l);
    begin
      tx_data_i <= d;
      tx_last_i <= l;
      tx_valid_i <= 1'b1;
      @(negedge sys_clk_i);
      while (tx_ready_o !== 1'b1) @(negedge sys_clk_i);
      @(posedge sys_clk_i);
    end
  endtask
  task do_reset(input integer n);
    begin
      rst_n_i <= 1'b0;
      inventory_i <= 1'b0;
      send <= 1'b0;
      repeat (n) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(negedge sys_clk_i);
      check("ready after reset", 8'h01, {7'h00, tx_ready_o});
      @(posedge sys_clk_i);
    end
  endtask
  task finish_test;
    begin
      if (fail_count == 0 && num_checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  initial begin
    seed = 32'h34a3_eb9f;
    fail_count = 0;
    num_checks = 0;
    {mode_i, speed_i, inventory_i, tx_data_i, tx_valid_i} = 0;
    {tx_last_i, send, pbyte, pwait, rst_n_i} = 0;
    do_reset(20);
    inventory_i <= 1'b1;
    t0 = $time;
    wait_ev(0, 20);
    @(posedge sys_clk_i);
    inventory_i <= 1'b0;
    wait_ev(3, 20000);
    span("inventory", `INV_SLOTS * `INV_SLOT_BITS * TICK, 250);
    check("last slot", {3'h0, `INV_SLOT_LAST}, {3'h0, inv_slot_o});
    @(posedge sys_clk_i);
    push(8'h00, 1'b1);
    tx_valid_i <= 1'b0;
    wait_ev(0, 20);
    check("reader field", 8'h01, {7'h00, field_on_o});
    wait_ev(4, 20000);
    // First pause is cut by the carrier phase; time the later ones
    wait_ev(5, 2000);
    t0 = $time;
    wait_ev(4, 40000);
    span("gap", (2 * `VT_BIT_CARRIERS - `VT_PAUSE_CARRIERS) * TICK, 16);
    t0 = $time;
    wait_ev(5, 2000);
    span("pause", `VT_PAUSE_CARRIERS * TICK, 16);
    @(posedge sys_clk_i);
    do_reset(2);
    for (i = 0; i < 2; i = i + 1) begin
      mode_i <= i ? `MODE_PAS_INIT : `MODE_ACT_INIT;
      speed_i <= `SPD_424;
      rnd = $random(seed);
      pbyte <= rnd[7:0] | 8'h01;
      pwait <= i ? 10'h10c : 10'h004;
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check("initiator field", 8'h01, {7'h00, field_on_o});
      @(posedge sys_clk_i);
      push(rnd[15:8], 1'b1);
      tx_valid_i <= 1'b0;
      wait_ev(0, 20);
      if (i == 0) wait_ev(7, 12000);
      @(posedge sys_clk_i);
      send <= 1'b1;
      wait_ev(2, 20000);
      check("reply", pbyte, rx_data_o);
      @(posedge sys_clk_i);
      do_reset(2);
    end
    mode_i <= `MODE_ACT_TGT;
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check("target field", 8'h00, {7'h00, field_on_o});
    @(posedge sys_clk_i);
    mode_i <= `MODE_PAS_TGT;
    for (i = 0; i < 16; i = i + 1) begin
      rnd = $random(seed);
      push(rnd[7:0], i == 15);
    end
    tx_valid_i <= 1'b0;
    @(negedge sys_clk_i);
    check("queue full", 8'h00, {7'h00, tx_ready_o});
    check("target waits", 8'h00, {7'h00, busy_o});
    @(posedge sys_clk_i);
    rnd = $random(seed);
    pbyte <= rnd[7:0] | 8'h01;
    pwait <= 10'h004;
    send <= 1'b1;
    wait_ev(2, 20000);
    check("command", pbyte, rx_data_o);
    wait_ev(6, 3000);
    wait_ev(1, 2000);
    check("passive field", 8'h00, {7'h00, field_on_o});
    finish_test;
  end
endmodule
